// file: core/tlog_pkg.sv
// shared constants, types and state codes of the logger configuration block
// ****************************************************************
// ****************************************************************
package tlog_pkg;
    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [15:0] ADDR_CLK0 = 16'h0200;
    localparam logic [15:0] ADDR_CLK1 = 16'h0201;
    localparam logic [15:0] ADDR_CLK2 = 16'h0202;
    localparam logic [15:0] ADDR_CLK3 = 16'h0203;
    localparam logic [15:0] ADDR_IVL_LO = 16'h0206;
    localparam logic [15:0] ADDR_IVL_HI = 16'h0207;
    localparam logic [15:0] ADDR_THR_LO = 16'h0208;
    localparam logic [15:0] ADDR_THR_HI = 16'h0209;
    localparam logic [15:0] ADDR_RES_LO = 16'h020C;
    localparam logic [15:0] ADDR_RES_HI = 16'h020D;
    localparam logic [15:0] ADDR_ALM_EN = 16'h0210;
    localparam logic [15:0] ADDR_OSC = 16'h0212;
    localparam logic [15:0] ADDR_MISSION = 16'h0213;
    // ****************************************************************
    // fields and codes
    // ****************************************************************
    localparam int IVL_W = 14;
    localparam int CODE_W = 11;
    localparam int LOG_AW = 17;
    localparam int DLY_W = 27;
    localparam int PRE_W = 28;
    localparam logic [LOG_AW-1:0] LOG_BASE = 17'h01000;
    localparam logic [LOG_AW-1:0] LOG_LAST = 17'h1F9FF;
    localparam logic [IVL_W-1:0] MIN_IVL_SEC = 14'h00B4;
    localparam logic [IVL_W-1:0] MIN_IVL_MIN = 14'h0003;
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;
    localparam logic [7:0] RC_BUSY = 8'hFF;
    localparam logic [7:0] RC_OK = 8'hAA;
    localparam logic [7:0] RC_IN_MISSION = 8'h22;
    localparam logic [7:0] RC_BAD_PARAM = 8'h77;
    localparam logic [15:0] RES_COLD = 16'h0000;
    localparam logic [15:0] RES_HOT_WIDE = 16'hFFE0;
    localparam logic [15:0] RES_HOT_NARROW = 16'hFF00;
    localparam logic [1:0] MC_FIXED_ONES = 2'h3;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam longint CLK_HZ = 250_000_000;
    localparam longint CLOCK_START_MS = 500;
    localparam int SEC_CYCLES = int'(CLK_HZ);
    localparam int START_DELAY_CYCLES = int'(CLK_HZ * CLOCK_START_MS / 1000);
    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tlog_bus_s;
    typedef struct packed {
        logic valid;
        logic under;
        logic over;
        logic [CODE_W-1:0] code;
    } tlog_conv_s;
    typedef struct packed {
        logic we;
        logic [LOG_AW-1:0] addr;
        logic [7:0] data;
    } tlog_log_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CLK_WAIT = 2'b01,
        ST_ARMED = 2'b10,
        ST_LOGGING = 2'b11
    } tlog_state_e;
endpackage

// file: core/tlog_encode.sv
// temperature result encoder
`timescale 1ns/1ps
module tlog_encode
    import tlog_pkg::*;
(
    input wire tlog_conv_s i_conv,
    input wire logic i_wide,
    output logic [15:0] o_result
);
    always_comb begin
        if (i_conv.under) begin
            o_result = RES_COLD;
        end else if (i_conv.over) begin
            o_result = i_wide ? RES_HOT_WIDE : RES_HOT_NARROW;
        end else if (i_wide) begin
            o_result = {i_conv.code, 5'h00};
        end else begin
            // narrow low byte is undefined; zero keeps it deterministic
            o_result = {i_conv.code[CODE_W-1:3], 8'h00};
        end
    end
endmodule

// file: core/tlog_tick.sv
// second, minute and sample-interval timing
`timescale 1ns/1ps
module tlog_tick
    import tlog_pkg::*;
#(
    parameter int SEC_LEN = SEC_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_osc_run,
    input wire logic i_count_run,
    input wire logic i_seconds_unit,
    input wire logic [IVL_W-1:0] i_interval,
    output logic o_sec_tick,
    output logic o_sample_tick
);
    logic [PRE_W-1:0] pre;
    logic [5:0] sec_in_min;
    logic [IVL_W-1:0] ivl_cnt;
    logic unit_tick;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre <= '0;
            o_sec_tick <= 1'b0;
        end else if (!i_osc_run) begin
            pre <= '0;
            o_sec_tick <= 1'b0;
        end else if (pre == PRE_W'(SEC_LEN - 1)) begin
            pre <= '0;
            o_sec_tick <= 1'b1;
        end else begin
            pre <= pre + 1'b1;
            o_sec_tick <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sec_in_min <= '0;
        end else if (o_sec_tick) begin
            sec_in_min <= (sec_in_min == SEC_PER_MIN - 1'b1) ? 6'h00 : sec_in_min + 1'b1;
        end
    end

    assign unit_tick = o_sec_tick && (i_seconds_unit || sec_in_min == SEC_PER_MIN - 1'b1);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ivl_cnt <= '0;
            o_sample_tick <= 1'b0;
        end else if (!i_count_run) begin
            ivl_cnt <= '0;
            o_sample_tick <= 1'b0;
        end else if (unit_tick && ivl_cnt + 1'b1 >= i_interval) begin
            ivl_cnt <= '0;
            o_sample_tick <= 1'b1;
        end else begin
            ivl_cnt <= unit_tick ? ivl_cnt + 1'b1 : ivl_cnt;
            o_sample_tick <= 1'b0;
        end
    end
endmodule

// file: core/tlog_config.sv
// configuration registers, clock and mission control of the logger
`timescale 1ns/1ps
module tlog_config
    import tlog_pkg::*;
#(
    parameter int SEC_LEN = SEC_CYCLES,
    parameter int START_DELAY = START_DELAY_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire tlog_bus_s i_bus,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_start_mission,
    input wire logic i_stop_mission,
    input wire logic i_clear_memory,
    output logic o_cmd_done,
    output logic [7:0] o_cmd_result,
    input wire tlog_conv_s i_conv,
    output logic o_conv_req,
    output logic o_conv_wide,
    output tlog_log_s o_log,
    output logic o_sample_count_inc,
    output logic o_high_alarm_flag,
    output logic o_low_alarm_flag,
    output logic o_mission_running,
    output logic o_oscillator_running
);
    // ****************************************************************
    // declarations
    // ****************************************************************
    tlog_state_e state;
    logic [31:0] seconds_clock;
    logic [31:0] clock_snap;
    logic [IVL_W-1:0] log_interval;
    logic [7:0] low_alarm_threshold;
    logic [7:0] high_alarm_threshold;
    logic [15:0] latest_result;
    logic high_alarm_enable;
    logic low_alarm_enable;
    logic seconds_unit_select;
    logic oscillator_enable;
    logic start_on_alarm;
    logic logging_format_select;
    logic logging_enable;
    logic spare_bit3;
    logic mem_cleared;
    logic [DLY_W-1:0] dly_cnt;
    logic dly_busy;
    logic sec_tick;
    logic sample_tick;
    logic [15:0] enc_result;
    logic high_hit;
    logic low_hit;
    logic in_mission;
    logic wr_ok;
    logic osc_turn_on;
    logic start_ok;
    logic conv_take;
    logic log_now;
    logic pend_low;
    logic [7:0] pend_data;
    logic [LOG_AW-1:0] log_addr;

    function automatic logic is_setup_addr(input logic [15:0] a);
        is_setup_addr = (a == ADDR_IVL_LO) || (a == ADDR_IVL_HI) || (a == ADDR_THR_LO) ||
                        (a == ADDR_THR_HI) || (a == ADDR_ALM_EN) || (a == ADDR_OSC) ||
                        (a == ADDR_MISSION) || (a[15:2] == ADDR_CLK0[15:2]);
    endfunction

    function automatic logic [7:0] clock_byte(input logic [31:0] v, input logic [1:0] idx);
        clock_byte = v[8*idx +: 8];
    endfunction

    // ****************************************************************
    // sub-blocks
    // ****************************************************************
    tlog_tick #(
        .SEC_LEN(SEC_LEN)
    ) u_tick (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_osc_run(o_oscillator_running),
        .i_count_run(in_mission),
        .i_seconds_unit(seconds_unit_select),
        .i_interval(log_interval),
        .o_sec_tick(sec_tick),
        .o_sample_tick(sample_tick)
    );

    tlog_encode u_encode (
        .i_conv(i_conv),
        .i_wide(o_conv_wide),
        .o_result(enc_result)
    );

    // ****************************************************************
    // control terms
    // ****************************************************************
    assign in_mission = (state == ST_ARMED) || (state == ST_LOGGING);
    assign o_mission_running = in_mission || (state == ST_CLK_WAIT);
    assign wr_ok = i_bus.wr && !o_mission_running && is_setup_addr(i_bus.addr);
    assign osc_turn_on = wr_ok && (i_bus.addr == ADDR_OSC) && i_bus.wdata[0] && !oscillator_enable;
    assign o_oscillator_running = oscillator_enable && !dly_busy;
    // armed waiting checks are always narrow
    assign o_conv_wide = logging_format_select && (state == ST_LOGGING);
    // a tick that lands on a stop is dropped, so no request leaves an idle block
    assign o_conv_req = sample_tick && in_mission;
    assign start_ok = (state == ST_IDLE) &&
                      (seconds_unit_select ? (log_interval >= MIN_IVL_SEC) : (log_interval >= MIN_IVL_MIN));
    assign conv_take = i_conv.valid && in_mission;
    assign high_hit = high_alarm_enable && (enc_result[15:8] >= high_alarm_threshold);
    assign low_hit = low_alarm_enable && (enc_result[15:8] <= low_alarm_threshold);
    assign log_now = conv_take && logging_enable &&
                     ((state == ST_LOGGING) || (high_hit || low_hit));

    // ****************************************************************
    // mission sequencing and command answer
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            o_cmd_done <= 1'b0;
            o_cmd_result <= RC_BUSY;
        end else begin
            o_cmd_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_start_mission) begin
                        o_cmd_done <= 1'b1;
                        if (!start_ok) begin
                            o_cmd_result <= RC_BAD_PARAM;
                        end else if (mem_cleared) begin
                            // answer held back until the first clock start delay ends
                            o_cmd_done <= 1'b0;
                            o_cmd_result <= RC_BUSY;
                            state <= ST_CLK_WAIT;
                        end else begin
                            o_cmd_result <= RC_OK;
                            state <= start_on_alarm ? ST_ARMED : ST_LOGGING;
                        end
                    end
                end
                ST_CLK_WAIT: begin
                    if (i_stop_mission) begin
                        state <= ST_IDLE;
                    end else if (!dly_busy) begin
                        o_cmd_done <= 1'b1;
                        o_cmd_result <= RC_OK;
                        state <= start_on_alarm ? ST_ARMED : ST_LOGGING;
                    end
                end
                ST_ARMED: begin
                    if (i_stop_mission) begin
                        state <= ST_IDLE;
                    end else if (conv_take && (high_hit || low_hit)) begin
                        state <= ST_LOGGING;
                    end else if (i_start_mission) begin
                        o_cmd_done <= 1'b1;
                        o_cmd_result <= RC_IN_MISSION;
                    end
                end
                ST_LOGGING: begin
                    if (i_stop_mission) begin
                        state <= ST_IDLE;
                    end else if (i_start_mission) begin
                        o_cmd_done <= 1'b1;
                        o_cmd_result <= RC_IN_MISSION;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // oscillator and first start delay
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            oscillator_enable <= 1'b0;
            seconds_unit_select <= 1'b0;
        end else if (state == ST_IDLE && i_start_mission && start_ok) begin
            oscillator_enable <= 1'b1;
        end else if (wr_ok && i_bus.addr == ADDR_OSC) begin
            oscillator_enable <= i_bus.wdata[0];
            seconds_unit_select <= i_bus.wdata[1];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mem_cleared <= 1'b1;
            dly_busy <= 1'b0;
            dly_cnt <= '0;
        end else if (dly_busy) begin
            if (dly_cnt == DLY_W'(START_DELAY - 1)) begin
                dly_busy <= 1'b0;
                mem_cleared <= 1'b0;
            end
            dly_cnt <= dly_cnt + 1'b1;
        end else if (mem_cleared && (osc_turn_on || (state == ST_IDLE && i_start_mission && start_ok))) begin
            dly_busy <= 1'b1;
            dly_cnt <= '0;
        end else if (i_clear_memory && !o_mission_running) begin
            mem_cleared <= 1'b1;
        end
    end

    // ****************************************************************
    // seconds clock
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            seconds_clock <= '0;
        end else if (wr_ok && i_bus.addr[15:2] == ADDR_CLK0[15:2]) begin
            seconds_clock[8*i_bus.addr[1:0] +: 8] <= i_bus.wdata;
        end else if (sec_tick) begin
            seconds_clock <= seconds_clock + 32'h00000001;
        end
    end

    // ****************************************************************
    // setup registers
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            log_interval <= '0;
            low_alarm_threshold <= '0;
            high_alarm_threshold <= '0;
            high_alarm_enable <= 1'b0;
            low_alarm_enable <= 1'b0;
            start_on_alarm <= 1'b0;
            logging_format_select <= 1'b0;
            logging_enable <= 1'b0;
            spare_bit3 <= 1'b0;
        end else if (wr_ok) begin
            case (i_bus.addr)
                ADDR_IVL_LO: log_interval[7:0] <= i_bus.wdata;
                ADDR_IVL_HI: log_interval[IVL_W-1:8] <= i_bus.wdata[IVL_W-9:0];
                ADDR_THR_LO: low_alarm_threshold <= i_bus.wdata;
                ADDR_THR_HI: high_alarm_threshold <= i_bus.wdata;
                ADDR_ALM_EN: begin
                    high_alarm_enable <= i_bus.wdata[1];
                    low_alarm_enable <= i_bus.wdata[0];
                end
                ADDR_MISSION: begin
                    start_on_alarm <= i_bus.wdata[5];
                    spare_bit3 <= i_bus.wdata[3];
                    logging_format_select <= i_bus.wdata[2];
                    logging_enable <= i_bus.wdata[0];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // results, alarm flags and log writes
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            latest_result <= '0;
        end else if (i_conv.valid) begin
            latest_result <= enc_result;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_high_alarm_flag <= 1'b0;
            o_low_alarm_flag <= 1'b0;
        end else begin
            // a hit in the clearing cycle survives
            o_high_alarm_flag <= (conv_take && high_hit) || (o_high_alarm_flag && !i_clear_memory);
            o_low_alarm_flag <= (conv_take && low_hit) || (o_low_alarm_flag && !i_clear_memory);
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sample_count_inc <= 1'b0;
        end else begin
            // the sample that wakes an armed mission is not counted
            o_sample_count_inc <= conv_take && (state == ST_LOGGING);
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_log <= '0;
            pend_low <= 1'b0;
            pend_data <= '0;
            log_addr <= LOG_BASE;
        end else begin
            o_log.we <= 1'b0;
            if (state == ST_IDLE && i_start_mission) begin
                log_addr <= LOG_BASE;
            end else if (pend_low) begin
                pend_low <= 1'b0;
                o_log <= '{we: 1'b1, addr: log_addr, data: pend_data};
                log_addr <= (log_addr == LOG_LAST) ? LOG_LAST : log_addr + 1'b1;
            end else if (log_now) begin
                // high byte first so it lands at the lower address
                o_log <= '{we: 1'b1, addr: log_addr, data: enc_result[15:8]};
                pend_low <= o_conv_wide;
                pend_data <= enc_result[7:0];
                log_addr <= (log_addr == LOG_LAST) ? LOG_LAST : log_addr + 1'b1;
            end
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clock_snap <= '0;
        end else if (i_bus.rd && i_bus.addr == ADDR_CLK0) begin
            // the whole count is frozen at the first byte so a carry cannot tear it
            clock_snap <= seconds_clock;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= '0;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_bus.rd;
            if (i_bus.rd) begin
                case (i_bus.addr)
                    ADDR_CLK0: o_rdata <= seconds_clock[7:0];
                    ADDR_CLK1: o_rdata <= clock_byte(clock_snap, 2'd1);
                    ADDR_CLK2: o_rdata <= clock_byte(clock_snap, 2'd2);
                    ADDR_CLK3: o_rdata <= clock_byte(clock_snap, 2'd3);
                    ADDR_IVL_LO: o_rdata <= log_interval[7:0];
                    ADDR_IVL_HI: o_rdata <= {2'b00, log_interval[IVL_W-1:8]};
                    ADDR_THR_LO: o_rdata <= low_alarm_threshold;
                    ADDR_THR_HI: o_rdata <= high_alarm_threshold;
                    ADDR_RES_LO: o_rdata <= latest_result[7:0];
                    ADDR_RES_HI: o_rdata <= latest_result[15:8];
                    ADDR_ALM_EN: o_rdata <= {6'h00, high_alarm_enable, low_alarm_enable};
                    ADDR_OSC: o_rdata <= {6'h00, seconds_unit_select, oscillator_enable};
                    ADDR_MISSION: o_rdata <= {MC_FIXED_ONES, start_on_alarm, 1'b1, spare_bit3,
                                              logging_format_select, 1'b0, logging_enable};
                    default: o_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

// file: verif/tlog_config_assertions.sv
// port checker of the logger configuration block
`timescale 1ns/1ps
module tlog_config_assertions
    import tlog_pkg::*;
#(
    parameter int SEC_LEN = SEC_CYCLES,
    parameter int START_DELAY = START_DELAY_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_start_mission,
    input wire logic i_clear_memory,
    input wire tlog_conv_s i_conv,
    input wire logic o_cmd_done,
    input wire logic [7:0] o_cmd_result,
    input wire logic o_conv_req,
    input wire logic o_conv_wide,
    input wire tlog_log_s o_log,
    input wire logic o_high_alarm_flag,
    input wire logic o_low_alarm_flag,
    input wire logic o_mission_running,
    input wire logic o_oscillator_running
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence wide_first;
        o_log.we && o_conv_wide && !$past(o_log.we);
    endsequence
    a_start_in_mission: assert property (i_start_mission && o_mission_running && !o_cmd_done |=>
        o_cmd_done && o_cmd_result == RC_IN_MISSION) else $error("start in mission not refused");
    a_ok_runs_osc: assert property (o_cmd_done && o_cmd_result == RC_OK |-> o_oscillator_running)
        else $error("oscillator idle after start");
    a_refused_idle: assert property (o_cmd_done && o_cmd_result == RC_BAD_PARAM |-> !o_mission_running)
        else $error("refused start left mission on");
    a_log_window: assert property (o_log.we |-> o_log.addr >= LOG_BASE && o_log.addr <= LOG_LAST)
        else $error("log write outside log area");
    a_wide_pair: assert property (wide_first |=> o_log.we && o_log.addr == $past(o_log.addr) + 17'h1
        && o_log.data[4:0] == 5'h00) else $error("wide sample pair broken");
    a_high_cause: assert property ($rose(o_high_alarm_flag) |-> $past(i_conv.valid) && o_mission_running)
        else $error("high flag without conversion");
    a_low_cause: assert property ($rose(o_low_alarm_flag) |-> $past(i_conv.valid) && o_mission_running)
        else $error("low flag without conversion");
    a_flags_hold: assert property (!i_clear_memory |=> o_high_alarm_flag >= $past(o_high_alarm_flag)
        && o_low_alarm_flag >= $past(o_low_alarm_flag)) else $error("alarm flag dropped");
    a_req_pulse: assert property (o_conv_req |-> o_mission_running ##1 !o_conv_req)
        else $error("conversion request malformed");
endmodule
bind tlog_config tlog_config_assertions #(.SEC_LEN(SEC_LEN), .START_DELAY(START_DELAY)) u_chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_start_mission(i_start_mission), .i_clear_memory(i_clear_memory),
    .i_conv(i_conv), .o_cmd_done(o_cmd_done), .o_cmd_result(o_cmd_result), .o_conv_req(o_conv_req),
    .o_conv_wide(o_conv_wide), .o_log(o_log), .o_high_alarm_flag(o_high_alarm_flag),
    .o_low_alarm_flag(o_low_alarm_flag), .o_mission_running(o_mission_running),
    .o_oscillator_running(o_oscillator_running));

// file: verif/tlog_host.sv
// host model: byte register access and threshold coding
`timescale 1ns/1ps
module tlog_host
    import tlog_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output tlog_bus_s o_bus
);
    initial o_bus = '0;
    function automatic logic [7:0] thr_code(input int deg);
        return 8'(2 * deg + 82);
    endfunction
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1 o_bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        #1 o_bus.wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1 o_bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        #1 o_bus.rd = 1'b0;
        d = i_rvalid ? i_rdata : 8'hXX;
    endtask
    // lowest byte first so the snapshot stays coherent
    task automatic rd_clock(output logic [31:0] s);
        for (int i = 0; i < 4; i++) rd(ADDR_CLK0 + 16'(i), s[8*i +: 8]);
    endtask
endmodule

// file: verif/tb_tlog_config.sv
// self-checking bench of the logger configuration block
`timescale 1ns/1ps
module tb_tlog_config
    import tlog_pkg::*;
;
    logic i_clk = 1'b0, i_nrst = 1'b0, start = 1'b0, stop = 1'b0, clr = 1'b0, rvalid, done, hf, lf, mrun, orun;
    logic [7:0] rdata, cres, v;
    logic [31:0] s;
    tlog_bus_s bus;
    tlog_conv_s conv = '0;
    tlog_log_s lw;
    logic ci, cw, cr;
    int bad_count = 0, n_tests = 0, n;
    always #2 i_clk = ~i_clk;
    tlog_config #(.SEC_LEN(10), .START_DELAY(20)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(bus),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_start_mission(start), .i_stop_mission(stop), .i_clear_memory(clr),
        .o_cmd_done(done), .o_cmd_result(cres), .i_conv(conv), .o_conv_req(cr), .o_conv_wide(cw), .o_log(lw),
        .o_sample_count_inc(ci), .o_high_alarm_flag(hf), .o_low_alarm_flag(lf), .o_mission_running(mrun),
        .o_oscillator_running(orun));
    tlog_host host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_bus(bus));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        host.rd(a, v);
        check("register", v, e);
    endtask
    // bounded wait: the cleared-state start adds the clock start delay
    task automatic cmd;
        @(posedge i_clk);
        #1 start = 1'b1;
        @(posedge i_clk);
        #1 start = 1'b0;
        for (n = 1; !done && n < 100; n++) @(posedge i_clk) #1;
    endtask
    task automatic pulse_conv(input tlog_conv_s c);
        @(posedge i_clk);
        #1 conv = c;
        @(posedge i_clk);
        #1 conv.valid = 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        rchk(ADDR_MISSION, 8'hD0);
        host.wr(ADDR_IVL_HI, 8'hFF);
        rchk(ADDR_IVL_HI, 8'h3F);
        host.wr(ADDR_ALM_EN, 8'hFF);
        rchk(ADDR_ALM_EN, 8'h03);
        host.wr(ADDR_MISSION, 8'h00);
        rchk(ADDR_MISSION, 8'hD0);
        rchk(16'h020A, 8'h00);
        for (int i = 0; i < 4; i++) host.wr(ADDR_CLK0 + 16'(i), 8'(8'h11 * (i + 1)));
        host.rd_clock(s);
        check("clock", s, 32'h44332211);
        host.wr(ADDR_IVL_HI, 8'h00);
        host.wr(ADDR_IVL_LO, 8'hB3);
        host.wr(ADDR_OSC, 8'h02);
        cmd();
        check("short seconds", cres, RC_BAD_PARAM);
        host.wr(ADDR_OSC, 8'h00);
        host.wr(ADDR_IVL_LO, 8'h02);
        cmd();
        check("short minutes", cres, RC_BAD_PARAM);
        host.wr(ADDR_IVL_LO, 8'h03);
        host.wr(ADDR_THR_LO, host.thr_code(-9));
        host.wr(ADDR_THR_HI, host.thr_code(23));
        host.wr(ADDR_MISSION, 8'h05);
        cmd();
        check("start", cres, RC_OK);
        check("start delay", n >= 20, 1);
        rchk(ADDR_OSC, 8'h01);
        host.wr(ADDR_THR_LO, 8'h00);
        rchk(ADDR_THR_LO, 8'h40);
        cmd();
        check("restart", cres, RC_IN_MISSION);
        pulse_conv('{valid: 1'b1, under: 1'b0, over: 1'b0, code: 11'h485});
        check("log high", {lw.we, lw.addr, lw.data, ci}, {1'b1, LOG_BASE, 8'h90, 1'b1});
        @(posedge i_clk);
        #1 check("log low", {lw.we, lw.addr, lw.data}, {1'b1, LOG_BASE + 17'h1, 8'hA0});
        check("flags", {hf, lf, cw}, 3'b101);
        rchk(ADDR_RES_HI, 8'h90);
        rchk(ADDR_RES_LO, 8'hA0);
        pulse_conv('{valid: 1'b1, under: 1'b0, over: 1'b1, code: 11'h000});
        rchk(ADDR_RES_HI, 8'hFF);
        rchk(ADDR_RES_LO, 8'hE0);
        pulse_conv('{valid: 1'b1, under: 1'b1, over: 1'b0, code: 11'h7FF});
        rchk(ADDR_RES_HI, 8'h00);
        check("low flag", {hf, lf}, 2'b11);
        for (n = 0; !cr && n < 2000; n++) @(posedge i_clk) #1;
        check("sample tick", cr, 1'b1);
        @(posedge i_clk);
        #1 stop = 1'b1;
        @(posedge i_clk);
        #1 {stop, clr} = 2'b01;
        @(posedge i_clk);
        #1 clr = 1'b0;
        host.wr(ADDR_OSC, 8'h00);
        check("cleared", {hf, lf, orun}, 3'b000);
        end_of_test();
    end
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule
